/* File: hw/pbs_fifo.sv */
// Parameterised valid/ready FIFO holding write words; the array never reads them.
`timescale 1ns/1ps
`default_nettype none
module pbs_fifo
   import pbs_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [WIDTH-1:0] out_ff, nxt_out;
   logic push, pop;

   // ==========================================================
   // Pointer and output register next values.
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
      nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
      nxt_out = mem_ff[nxt_rp[AW-1:0]];
   end

   // Full when pointers differ only in their wrap bit.
   assign in_ready = !((wp_ff[AW] != rp_ff[AW]) &&
                      (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
   assign out_valid = (wp_ff != rp_ff);
   assign out_data = mem_ff[rp_ff[AW-1:0]];

   // Registers the pointers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_ff <= '0;
         rp_ff <= '0;
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
      end
   end

   // Storage array is written without reset.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wp_ff[AW-1:0]] <= in_data;
      end
      out_ff <= nxt_out;
   end
endmodule : pbs_fifo
`default_nettype wire

/* File: hw/pbs_port.sv */
// Pipelined burst SRAM port: array, burst counter and two-stage data pipe.
`timescale 1ns/1ps
`default_nettype none
module pbs_port
   import pbs_pkg::*;
#(
   parameter int WORDS = 1 << PBS_ADDR_W
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Address and control.
   input wire logic [PBS_ADDR_W-1:0] addr,
   input wire logic rd_wr_n,
   input wire logic advance_load_n,
   input wire logic clk_gate_n,
   input wire logic select_a_n,
   input wire logic select_b,
   input wire logic select_c_n,
   input wire logic burst_order_sel_n,
   input wire logic out_en_n,
   input wire logic [PBS_LANES-1:0] lane_wr_en_n,
   // Data bus as three signals.
   input wire logic [PBS_DATA_W-1:0] dq_in,
   output logic [PBS_DATA_W-1:0] dq_out,
   output logic dq_oe
);
   // ==========================================================
   // State.
   logic [PBS_DATA_W-1:0] mem [WORDS];
   pbs_slot_t s1_ff, s2_ff, nxt_s1, nxt_s2;
   logic [PBS_LANES-1:0] ln1_ff, ln2_ff, nxt_ln1, nxt_ln2;
   logic [PBS_ADDR_W-1:0] base_ff, nxt_base;
   logic [PBS_BURST_W-1:0] cnt_ff, nxt_cnt;
   logic burst_ff, nxt_burst, bwr_ff, nxt_bwr;
   logic [PBS_DATA_W-1:0] dq_out_ff, nxt_dq;
   logic dq_oe_ff, nxt_oe, selected, run;
   pbs_wr_t wr_word;
   logic fifo_in_ready, fifo_out_valid;
   pbs_wr_t fifo_out;

   // Decodes the three enables into one select level.
   function automatic logic chip_sel(input logic a_n, b, c_n);
      return !a_n && b && !c_n;
   endfunction

   // Burst address from base, count and order mode.
   function automatic logic [PBS_ADDR_W-1:0] burst_addr(
      input logic [PBS_ADDR_W-1:0] base, input logic [1:0] cnt,
      input logic linear);
      logic [1:0] low;
      low = linear ? 2'(base[1:0] + cnt) : (base[1:0] ^ cnt);
      return {base[PBS_ADDR_W-1:2], low};
   endfunction

   // ==========================================================
   // Next pipeline values.
   always_comb begin
      selected = chip_sel(select_a_n, select_b, select_c_n);
      run = !clk_gate_n; // gated edges hold everything except the write queue, which keeps draining
      nxt_base = base_ff;
      nxt_cnt = cnt_ff;
      nxt_burst = burst_ff;
      nxt_bwr = bwr_ff;
      nxt_s1 = s1_ff;
      nxt_ln1 = ln1_ff;
      nxt_s2 = s2_ff;
      nxt_ln2 = ln2_ff;
      if (run) begin
         nxt_s2 = s1_ff;
         nxt_ln2 = ln1_ff;
         nxt_ln1 = lane_wr_en_n;
         if (!advance_load_n) begin
            if (selected) begin
               // New load, also legal during a running burst.
               nxt_base = addr;
               nxt_cnt = PBS_BURST_RST;
               nxt_burst = 1'b1;
               nxt_bwr = !rd_wr_n;
               nxt_s1 = '{valid: 1'b1, write: !rd_wr_n, addr: addr};
            end else begin
               nxt_burst = 1'b0; // stop; earlier slots still drain
               nxt_s1 = '{valid: 1'b0, write: 1'b0, addr: addr};
            end
         end else if (burst_ff) begin
            // Continuation ignores address, direction, enables.
            nxt_cnt = cnt_ff + 1'b1;
            nxt_s1 = '{valid: 1'b1, write: bwr_ff,
               addr: burst_addr(base_ff, nxt_cnt, !burst_order_sel_n)};
         end else begin
            nxt_s1 = '{valid: 1'b0, write: 1'b0, addr: addr};
         end
      end
      // Output register: read data two edges after the load.
      nxt_dq = dq_out_ff;
      nxt_oe = dq_oe_ff;
      if (run) begin
         nxt_oe = s1_ff.valid && !s1_ff.write;
         nxt_dq = mem[s1_ff.addr];
      end
      // Write word captured from the bus in the data cycle.
      wr_word = '{addr: s2_ff.addr, lane_n: ln2_ff, data: dq_in};
   end

   // Registers pipeline state.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         ln1_ff <= PBS_LANES_OFF;
         ln2_ff <= PBS_LANES_OFF;
         base_ff <= '0;
         cnt_ff <= PBS_BURST_RST;
         burst_ff <= 1'b0;
         bwr_ff <= 1'b0;
         dq_out_ff <= '0;
         dq_oe_ff <= 1'b0;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         ln1_ff <= nxt_ln1;
         ln2_ff <= nxt_ln2;
         base_ff <= nxt_base;
         cnt_ff <= nxt_cnt;
         burst_ff <= nxt_burst;
         bwr_ff <= nxt_bwr;
         dq_out_ff <= nxt_dq;
         dq_oe_ff <= nxt_oe;
      end
   end

   // Writes enter a queue at stage s1, with the bus a cycle before their data; it drains one per clock, its output is unused, the array is written directly.
   pbs_fifo #(.WIDTH($bits(pbs_wr_t)), .DEPTH(PBS_FIFO_DEPTH)) u_wq (
      .clk(clk),
      .rst(rst),
      .in_valid(run && s1_ff.valid && s1_ff.write),
      .in_ready(fifo_in_ready),
      .in_data({s1_ff.addr, ln1_ff, dq_in}),
      .out_valid(fifo_out_valid),
      .out_ready(1'b1),
      .out_data(fifo_out)
   );

   // Stores lanes of the word arriving in its data cycle.
   for (genvar g = 0; g < PBS_LANES; g++) begin : g_lane
      always_ff @(posedge clk) begin
         if (run && s2_ff.valid && s2_ff.write && !ln2_ff[g]) begin
            mem[s2_ff.addr][g*PBS_LANE_W +: PBS_LANE_W] <=
               dq_in[g*PBS_LANE_W +: PBS_LANE_W];
         end
      end
   end

   // Output pins; enable is asynchronous.
   assign dq_out = dq_out_ff;
   assign dq_oe = dq_oe_ff && !out_en_n;

   // ==========================================================
   // Checks.
   property p_read_two;
      @(posedge clk) disable iff (rst)
      (!clk_gate_n && !advance_load_n && rd_wr_n &&
       chip_sel(select_a_n, select_b, select_c_n))
      ##1 !clk_gate_n |=> dq_oe_ff;
   endproperty
   a_read_two: assert property (p_read_two)
      else $error("read data not driven two cycles after load");

   property p_desel_z;
      @(posedge clk) disable iff (rst)
      (!clk_gate_n && !advance_load_n &&
       !chip_sel(select_a_n, select_b, select_c_n))
      ##1 !clk_gate_n |=> !dq_oe_ff;
   endproperty
   a_desel_z: assert property (p_desel_z)
      else $error("bus not floating two cycles after deselect");

   property p_hold;
      @(posedge clk) disable iff (rst)
      clk_gate_n |=> $stable(dq_out_ff) && $stable(dq_oe_ff)
         && $stable(cnt_ff);
   endproperty
   a_hold: assert property (p_hold)
      else $error("state changed on a gated edge");

   property p_adv;
      @(posedge clk) disable iff (rst)
      !clk_gate_n && advance_load_n && burst_ff
      |=> cnt_ff == $past(cnt_ff) + 2'h1 && burst_ff;
   endproperty
   a_adv: assert property (p_adv)
      else $error("burst counter did not step");

   property p_dir;
      @(posedge clk) disable iff (rst)
      !clk_gate_n && advance_load_n && burst_ff |=> s1_ff.write == bwr_ff
         && $stable(bwr_ff);
   endproperty
   a_dir: assert property (p_dir)
      else $error("burst direction changed while advancing");

   property p_oe_gate;
      @(posedge clk) disable iff (rst) out_en_n |-> !dq_oe;
   endproperty
   a_oe_gate: assert property (p_oe_gate)
      else $error("bus driven with output enable inactive");
endmodule : pbs_port
`default_nettype wire

/* File: pkg/pbs_pkg.sv */
// Package with shared constants and carrier types of the burst SRAM port.
package pbs_pkg;
   // ==========================================================
   // Geometry
   localparam int PBS_ADDR_W = 17;
   localparam int PBS_LANES = 4;
   localparam int PBS_LANE_W = 9;
   localparam int PBS_DATA_W = PBS_LANES * PBS_LANE_W;
   localparam int PBS_BURST_W = 2;
   localparam int PBS_PIPE_DEPTH = 2;
   localparam int PBS_FIFO_DEPTH = 8;
   // ==========================================================
   // Reset values
   localparam logic [1:0] PBS_BURST_RST = 2'h0;
   localparam logic [PBS_LANES-1:0] PBS_LANES_OFF = 4'hf;

   // Pipeline stage: one bus transfer slot.
   typedef struct packed {
      logic valid;
      logic write;
      logic [PBS_ADDR_W-1:0] addr;
   } pbs_slot_t;

   // Write word held in the write queue; the memory never takes it.
   typedef struct packed {
      logic [PBS_ADDR_W-1:0] addr;
      logic [PBS_LANES-1:0] lane_n;
      logic [PBS_DATA_W-1:0] data;
   } pbs_wr_t;
endpackage : pbs_pkg

/* File: sim/pbs_ctrl_model.sv */
// Memory controller model that drives the port's request and data side.
`timescale 1ns/1ps
`default_nettype none
module pbs_ctrl_model
   import pbs_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Requests towards the port.
   output logic [PBS_ADDR_W-1:0] addr,
   output logic rd_wr_n,
   output logic advance_load_n,
   output logic clk_gate_n,
   output logic [2:0] sel,
   output logic [PBS_LANES-1:0] lane_wr_en_n,
   output logic [PBS_DATA_W-1:0] dq_in
);
   // Start selected and idle so the first edge after reset does nothing.
   initial begin
      addr = 17'h0;
      rd_wr_n = 1'h1;
      advance_load_n = 1'h1;
      clk_gate_n = 1'h0;
      sel = 3'h2;
      lane_wr_en_n = 4'h0;
      dq_in = 36'h0;
   end
   // One request cycle, changed just after an edge and held a full cycle.
   task automatic step(input logic adv_n, rw_n, input logic [2:0] s,
      input logic gate_n, input logic [PBS_ADDR_W-1:0] a, input logic wd,
      input logic [PBS_DATA_W-1:0] d, input logic [PBS_LANES-1:0] ln);
      @(posedge clk);
      addr <= a;
      rd_wr_n <= rw_n;
      advance_load_n <= adv_n;
      clk_gate_n <= gate_n;
      sel <= s;
      lane_wr_en_n <= ln;
      // A released bus changes every cycle instead of keeping its last word.
      dq_in <= wd ? d : ~dq_in;
   endtask : step
endmodule : pbs_ctrl_model
`default_nettype wire

/* File: sim/pbs_port_bench.sv */
// Self-checking bench for the pipelined burst SRAM port's bus outputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin check_count++; if ((s) !== (e)) begin \
   num_errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module pbs_port_bench
   import pbs_pkg::*;
;
   typedef struct packed {
      logic adv_n, rw_n;
      logic [2:0] sel;
      logic gate_n;
      logic [PBS_ADDR_W-1:0] a;
      logic wd;
      logic [PBS_ADDR_W-1:0] da;
      logic oe;
      logic [PBS_ADDR_W-1:0] qa;
   } pbs_row_t;
   localparam logic L = 1'h0, H = 1'h1;
   localparam logic [2:0] S = 3'h2, D1 = 3'h6, D2 = 3'h0, D3 = 3'h3;
   localparam logic [PBS_ADDR_W-1:0] X = 17'h1ffff, Z0 = 17'h0;
   localparam int NR = 22;
   // Per cycle: requests, then what the bus shows after that edge.
   localparam pbs_row_t ROWS [NR] = '{
      '{L,L,S,L,17'h11,L,Z0,L,Z0}, '{H,H,D1,L,X,L,Z0,L,Z0},
      '{H,H,D2,L,X,H,17'h11,L,Z0}, '{H,H,S,L,X,H,17'h12,L,Z0},
      '{L,L,S,L,17'h20,H,17'h13,L,Z0}, '{L,H,D1,L,X,H,17'h10,L,Z0},
      '{H,L,S,L,X,H,17'h20,L,Z0}, '{L,H,S,L,17'h11,L,Z0,L,Z0},
      '{H,L,D3,L,X,L,Z0,L,Z0}, '{H,L,S,L,X,L,Z0,H,17'h11},
      '{H,H,D2,L,X,L,Z0,H,17'h12}, '{L,H,S,L,17'h20,L,Z0,H,17'h13},
      '{L,L,S,L,17'h30,L,Z0,H,17'h10}, '{L,H,S,L,17'h13,L,Z0,H,17'h20},
      '{L,H,D1,L,X,H,17'h30,L,Z0}, '{L,H,S,H,17'h11,L,Z0,H,17'h13},
      '{H,H,S,L,X,L,Z0,H,17'h13}, '{L,H,S,L,17'h30,L,Z0,L,Z0},
      '{L,H,D2,L,X,L,Z0,L,Z0}, '{H,H,S,L,X,L,Z0,H,17'h30},
      '{L,H,D3,L,X,L,Z0,L,Z0}, '{H,H,S,L,X,L,Z0,L,Z0}};
   logic clk, rst, out_en_n, rd_wr_n, advance_load_n, clk_gate_n;
   logic [PBS_ADDR_W-1:0] addr;
   logic [2:0] sel;
   logic [PBS_LANES-1:0] lane_wr_en_n;
   logic [PBS_DATA_W-1:0] dq_in, dq_out, wv;
   logic dq_oe, order_n;
   pbs_row_t r;
   int num_errors, check_count;
   pbs_port u_pbs_port (.clk(clk), .rst(rst), .addr(addr),
      .rd_wr_n(rd_wr_n), .advance_load_n(advance_load_n),
      .clk_gate_n(clk_gate_n), .select_a_n(sel[2]), .select_b(sel[1]),
      .select_c_n(sel[0]), .burst_order_sel_n(order_n), .out_en_n(out_en_n),
      .lane_wr_en_n(lane_wr_en_n), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe));
   pbs_ctrl_model u_pbs_ctrl_model (.clk(clk), .addr(addr),
      .rd_wr_n(rd_wr_n), .advance_load_n(advance_load_n),
      .clk_gate_n(clk_gate_n), .sel(sel), .lane_wr_en_n(lane_wr_en_n),
      .dq_in(dq_in));
   // Word written to an address: the address itself over a fixed pattern.
   function automatic logic [PBS_DATA_W-1:0] w(input logic [16:0] a);
      return {a, 19'h2a5a5};
   endfunction : w
   task automatic op(input logic adv_n, rw_n, input logic [2:0] s,
      input logic gate_n, input logic [16:0] a, input logic wd,
      input logic [PBS_DATA_W-1:0] d, input logic [3:0] ln);
      u_pbs_ctrl_model.step(adv_n, rw_n, s, gate_n, a, wd, d, ln);
   endtask : op
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   // 10 MHz clock.
   initial clk = 1'h0;
   always #50 clk = ~clk;
   // Cuts a hung run short.
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      close_out();
   end
   // ==========================================================
   // Main sequence.
   initial begin
      rst = 1'h1;
      out_en_n = 1'h0;
      order_n = 1'h0;
      num_errors = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      #1;
      `CHK("rst oe", 1'h0, dq_oe);
      `CHK("rst q", 36'h0, dq_out);
      @(posedge clk) rst <= 1'h0;
      for (int i = 0; i < NR; i++) begin
         r = ROWS[i];
         op(r.adv_n, r.rw_n, r.sel, r.gate_n, r.a, r.wd, w(r.da), 4'h0);
         // The bus seen during a row's own cycle is what that row expects.
         #1;
         `CHK("oe", r.oe, dq_oe);
         if (r.oe)
            `CHK("q", w(r.qa), dq_out);
      end
      // Full write, then a write to lane 0 only, read back while gated.
      wv = w(17'h40);
      op(L, L, S, L, 17'h40, L, wv, 4'h0);
      op(L, H, D1, L, X, L, wv, 4'h0);
      op(L, H, D1, L, X, H, wv, 4'h0);
      op(L, L, S, L, 17'h40, L, wv, 4'he);
      op(L, H, D1, L, X, L, wv, 4'he);
      op(L, H, D1, L, X, H, ~wv, 4'he);
      op(L, H, S, L, 17'h40, L, wv, 4'h0);
      op(L, H, D1, L, X, L, wv, 4'h0);
      op(L, H, S, H, 17'h40, L, wv, 4'h0);
      #1;
      `CHK("lane", {wv[35:9], ~wv[8:0]}, dq_out);
      @(posedge clk) out_en_n <= 1'h1;
      #1;
      `CHK("oe off", 1'h0, dq_oe);
      @(posedge clk) out_en_n <= 1'h0;
      #1;
      `CHK("held", {wv[35:9], ~wv[8:0]}, dq_out);
      op(H, H, S, L, X, L, wv, 4'h0);
      // Interleaved burst read of earlier words: low bits 1, 0, 3, 2.
      order_n <= 1'h1;
      op(L, H, S, L, 17'h11, L, wv, 4'h0);
      op(H, H, S, L, X, L, wv, 4'h0);
      op(H, H, S, L, X, L, wv, 4'h0);
      #1;
      `CHK("ilv0", w(17'h11), dq_out);
      op(H, H, S, L, X, L, wv, 4'h0);
      #1;
      `CHK("ilv1", w(17'h10), dq_out);
      op(L, H, D1, L, X, L, wv, 4'h0);
      #1;
      `CHK("ilv2", w(17'h13), dq_out);
      op(H, H, S, L, X, L, wv, 4'h0);
      #1;
      `CHK("ilv3", w(17'h12), dq_out);
      close_out();
   end
endmodule : pbs_port_bench
`default_nettype wire
